// ### logic/ssm_sram_port.sv
// serial sram command port with single, dual and quad lanes
`default_nettype none
// Overview of operation
// - chip select high deselects, resets sequence and floats all outputs.
// - inputs sampled on sck rising edge, outputs change after falling edge.
// - pause pin low mid-sequence suspends without losing sequence state.
// - pause asserted with sck high starts at next sck falling edge.
// - pause released with sck high resumes at next sck falling edge.
// - during pause, sck and data input are ignored; select stays low.
// - outputs float at once on pause fall, drive again on its rise.
// - quad lane mode has no pause; the pause pin is lane three.
// - dual mode turns data in and out into lanes zero and one.
// - unused pin is lane two in single and dual modes; quad mode uses it.
// - every operation opens with an eight-bit instruction.
// - instruction, address and data move most significant bit first.
// - mode register bits 7:6 pick byte, page or sequential access.
// - byte mode moves exactly one data byte after the address.
// - page mode wraps the address within its 32-byte page.
// - sequential mode crosses pages and rolls over to zero.
// - write is instruction, address (top six bits ignored), data bytes.
// - reads advance the address per byte and roll over at the top; page mode wraps within its page.
// - code 03 reads memory, code 02 writes memory.
// - code 05 reads the mode register, code 01 writes it.
// - mode field resets to sequential; value 11 is reserved.
// - code 3b enters dual lanes, 38 enters quad lanes.
// - code ff returns to single lane, sent at the current width.
module ssm_sram_port #(
  parameter int ADDR_W = ssm_pkg::ADDR_W
) (
  input  wire logic       I_MCLK,
  input  wire logic       I_RESET,
  input  wire logic       I_CS_N,
  input  wire logic       I_SCK,
  input  wire logic [3:0] I_LANE,
  output var  logic [3:0] O_LANE,
  output var  logic [3:0] O_LANE_OE
);
  logic [5:0]          s1_q, s2_q;
  logic                sck_old_q, cs_n_s, sck_s;
  logic [3:0]          lane_s;
  logic                sck_rise, sck_fall;
  logic                quad, pause_low, we;
  logic                rise_ok, fall_ok;
  logic [2:0]          w;
  logic [23:0]         sh_n;
  logic [4:0]          cnt_n;
  logic [7:0]          ob;
  logic [7:0]          mem [2**ADDR_W];

  ssm_pkg::ssm_state_t st_q, st_d;
  ssm_pkg::ssm_lane_t  lane_q, lane_d;
  logic [1:0]          mode_q, mode_d;
  logic [23:0]         sh_q, sh_d;
  logic [4:0]          cnt_q, cnt_d;
  logic [ADDR_W-1:0]   addr_q, addr_d;
  logic                rd_q, rd_d;
  logic                src_mode_q, src_mode_d;
  logic [3:0]          ocnt_q, ocnt_d;
  logic [7:0]          osh_q, osh_d;
  logic                drv_q, drv_d;
  logic                paused_q, paused_d;
  logic [3:0]          out_q, out_d;
  logic [3:0]          oe_q, oe_d;

  // msb arrives first, so new bits enter at the bottom
  function automatic logic [23:0] shift_in(logic [23:0] v, logic [3:0] d,
                                           ssm_pkg::ssm_lane_t l);
    unique case (l)
      ssm_pkg::LANE_DUAL: shift_in = {v[21:0], d[1:0]};
      ssm_pkg::LANE_QUAD: shift_in = {v[19:0], d[3:0]};
      default:            shift_in = {v[22:0], d[0]};
    endcase
  endfunction

  function automatic logic [ADDR_W-1:0] next_addr(logic [ADDR_W-1:0] a,
                                                  logic [1:0] m);
    logic [ssm_pkg::PAGE_W-1:0] low;
    low = a[ssm_pkg::PAGE_W-1:0] + 5'h01;
    if (m == ssm_pkg::MODE_PAGE) begin
      next_addr = {a[ADDR_W-1:ssm_pkg::PAGE_W], low};
    end else begin
      next_addr = a + 1'b1;
    end
  endfunction

  // pins are asynchronous to I_MCLK; lanes share the sck delay
  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      s1_q      <= ssm_pkg::SYNC_RESET;
      s2_q      <= ssm_pkg::SYNC_RESET;
      sck_old_q <= 1'b0;
    end else begin
      s1_q      <= {I_LANE, I_SCK, I_CS_N};
      s2_q      <= s1_q;
      sck_old_q <= s2_q[1];
    end
  end

  assign cs_n_s    = s2_q[0];
  assign sck_s     = s2_q[1];
  assign lane_s    = s2_q[5:2];
  assign sck_rise  = sck_s & ~sck_old_q;
  assign sck_fall  = ~sck_s & sck_old_q;
  assign quad      = (lane_q == ssm_pkg::LANE_QUAD);
  assign pause_low = ~quad & ~lane_s[3];
  assign w         = quad ? 3'h4
                   : (lane_q == ssm_pkg::LANE_DUAL) ? 3'h2 : 3'h1;
  assign sh_n      = shift_in(sh_q, lane_s, lane_q);
  assign cnt_n     = cnt_q + {2'h0, w};

  // pause follows the pin only with sck low or on its falling edge; deselect or quad mode clears it at once
  always_comb begin
    paused_d = paused_q;
    if (cs_n_s || quad) begin
      paused_d = 1'b0;
    end else if (!sck_s || sck_fall) begin
      paused_d = pause_low;
    end
  end

  // edges around a pause boundary are swallowed as well
  assign rise_ok = sck_rise & ~paused_q & ~paused_d;
  assign fall_ok = sck_fall & ~paused_q & ~paused_d;

  always_comb begin
    st_d       = st_q;
    lane_d     = lane_q;
    mode_d     = mode_q;
    sh_d       = sh_q;
    cnt_d      = cnt_q;
    addr_d     = addr_q;
    rd_d       = rd_q;
    src_mode_d = src_mode_q;
    ocnt_d     = ocnt_q;
    osh_d      = osh_q;
    drv_d      = drv_q;
    out_d      = out_q;
    we         = 1'b0;
    ob         = osh_q;
    if (cs_n_s) begin
      st_d   = ssm_pkg::ST_CMD;
      cnt_d  = 5'h00;
      ocnt_d = 4'h0;
      drv_d  = 1'b0;
    end else if (rise_ok) begin
      sh_d  = sh_n;
      cnt_d = cnt_n;
      unique case (st_q)
        ssm_pkg::ST_CMD: begin
          if (cnt_n == ssm_pkg::INSTR_BITS) begin
            cnt_d      = 5'h00;
            src_mode_d = 1'b0;
            st_d       = ssm_pkg::ST_IGN;
            unique case (sh_n[7:0])
              ssm_pkg::CMD_READ, ssm_pkg::CMD_WRITE: begin
                st_d = ssm_pkg::ST_ADDR;
                rd_d = (sh_n[7:0] == ssm_pkg::CMD_READ);
              end
              ssm_pkg::CMD_READ_MODE: begin
                st_d       = ssm_pkg::ST_RD;
                src_mode_d = 1'b1;
              end
              ssm_pkg::CMD_WRITE_MODE: st_d = ssm_pkg::ST_MWR;
              ssm_pkg::CMD_ENTER_DUAL: lane_d = ssm_pkg::LANE_DUAL;
              ssm_pkg::CMD_ENTER_QUAD: lane_d = ssm_pkg::LANE_QUAD;
              ssm_pkg::CMD_EXIT_MULTI: lane_d = ssm_pkg::LANE_SINGLE;
              default: st_d = ssm_pkg::ST_IGN;
            endcase
          end
        end
        ssm_pkg::ST_ADDR: begin
          if (cnt_n == ssm_pkg::ADDR_BITS) begin
            cnt_d  = 5'h00;
            addr_d = sh_n[ADDR_W-1:0];
            if (!rd_q) begin
              st_d = ssm_pkg::ST_WR;
            end else if (lane_q == ssm_pkg::LANE_SINGLE) begin
              st_d = ssm_pkg::ST_RD;
            end else begin
              st_d = ssm_pkg::ST_DUMMY;
            end
          end
        end
        ssm_pkg::ST_DUMMY: begin
          if (cnt_n == ssm_pkg::DUMMY_BITS) begin
            cnt_d = 5'h00;
            st_d  = ssm_pkg::ST_RD;
          end
        end
        ssm_pkg::ST_WR: begin
          if (cnt_n == ssm_pkg::DATA_BITS) begin
            cnt_d  = 5'h00;
            we     = 1'b1;
            addr_d = next_addr(addr_q, mode_q);
            if (mode_q == ssm_pkg::MODE_BYTE) begin
              st_d = ssm_pkg::ST_IGN;
            end
          end
        end
        ssm_pkg::ST_MWR: begin
          if (cnt_n == ssm_pkg::DATA_BITS) begin
            st_d = ssm_pkg::ST_IGN;
            // reserved field value is refused; low bits are not stored
            if (sh_n[ssm_pkg::MODE_HI:ssm_pkg::MODE_LO]
                != ssm_pkg::MODE_RSVD) begin
              mode_d = sh_n[ssm_pkg::MODE_HI:ssm_pkg::MODE_LO];
            end
          end
        end
        default: cnt_d = cnt_q;
      endcase
    end else if (fall_ok && st_q == ssm_pkg::ST_RD) begin
      drv_d = 1'b1;
      if (ocnt_q == 4'h0) begin
        ob = src_mode_q ? {mode_q, 6'h00} : mem[addr_q];
      end
      if (ocnt_q == 4'h0 && cnt_q != 5'h00 && !src_mode_q
          && mode_q == ssm_pkg::MODE_BYTE) begin
        st_d  = ssm_pkg::ST_IGN;
        drv_d = 1'b0;
      end
      unique case (lane_q)
        ssm_pkg::LANE_DUAL: out_d = {2'h0, ob[7:6]};
        ssm_pkg::LANE_QUAD: out_d = ob[7:4];
        default:            out_d = {2'h0, ob[7], 1'b0};
      endcase
      osh_d  = ob << w;
      ocnt_d = ocnt_q + {1'b0, w};
      if (ocnt_d == ssm_pkg::BYTE_BITS) begin
        ocnt_d = 4'h0;
        cnt_d  = 5'h01;
        if (!src_mode_q) begin
          addr_d = next_addr(addr_q, mode_q);
        end
      end
    end
    if (st_d != ssm_pkg::ST_RD) begin
      drv_d = 1'b0;
    end
    unique case (lane_q)
      ssm_pkg::LANE_DUAL: oe_d = ssm_pkg::OE_DUAL;
      ssm_pkg::LANE_QUAD: oe_d = ssm_pkg::OE_QUAD;
      default:            oe_d = ssm_pkg::OE_SINGLE;
    endcase
    // pause floats the lanes at once, whatever sck is doing
    if (!drv_d || cs_n_s || pause_low) begin
      oe_d = 4'h0;
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      st_q       <= ssm_pkg::ST_CMD;
      lane_q     <= ssm_pkg::LANE_SINGLE;
      mode_q     <= ssm_pkg::MODE_RESET;
      sh_q       <= 24'h000000;
      cnt_q      <= 5'h00;
      addr_q     <= '0;
      rd_q       <= 1'b0;
      src_mode_q <= 1'b0;
      ocnt_q     <= 4'h0;
      osh_q      <= 8'h00;
      drv_q      <= 1'b0;
      paused_q   <= 1'b0;
      out_q      <= 4'h0;
      oe_q       <= 4'h0;
    end else begin
      st_q       <= st_d;
      lane_q     <= lane_d;
      mode_q     <= mode_d;
      sh_q       <= sh_d;
      cnt_q      <= cnt_d;
      addr_q     <= addr_d;
      rd_q       <= rd_d;
      src_mode_q <= src_mode_d;
      ocnt_q     <= ocnt_d;
      osh_q      <= osh_d;
      drv_q      <= drv_d;
      paused_q   <= paused_d;
      out_q      <= out_d;
      oe_q       <= oe_d;
    end
  end

  // array has no reset; contents are undefined until written
  always_ff @(posedge I_MCLK) begin
    if (we) begin
      mem[addr_q] <= sh_n[7:0];
    end
  end

  assign O_LANE    = out_q;
  assign O_LANE_OE = oe_q;
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (I_RESET);

  deselect_float_a: assert property (cs_n_s |=> O_LANE_OE == 4'h0)
    else $error("lanes driven while deselected");
  pause_float_a: assert property (pause_low |=> O_LANE_OE == 4'h0)
    else $error("lanes driven during pause");
  input_rise_a: assert property (
    !cs_n_s && $changed(sh_q) |-> $past(sck_rise))
    else $error("input shifted without sck rise");
  output_fall_a: assert property (
    $changed(O_LANE) && $past(!cs_n_s) |-> $past(sck_fall))
    else $error("output changed without sck fall");
  pause_freeze_a: assert property (
    paused_q && paused_d |=> $stable(cnt_q) && $stable(st_q))
    else $error("sequence moved during pause");
  quad_no_pause_a: assert property (quad |-> !paused_q)
    else $error("pause active in quad mode");
  ignore_hold_a: assert property (
    st_q == ssm_pkg::ST_IGN && !cs_n_s |=> st_q == ssm_pkg::ST_IGN
      && O_LANE_OE == 4'h0)
    else $error("ignored sequence resumed");
  page_wrap_a: assert property (
    we && mode_q == ssm_pkg::MODE_PAGE |=>
      addr_q[ADDR_W-1:ssm_pkg::PAGE_W]
        == $past(addr_q[ADDR_W-1:ssm_pkg::PAGE_W]))
    else $error("page mode left its page");
  seq_roll_a: assert property (
    we && mode_q == ssm_pkg::MODE_SEQ && &addr_q |=> addr_q == '0)
    else $error("sequential address did not roll over");
  byte_once_a: assert property (
    we && mode_q == ssm_pkg::MODE_BYTE |=> st_q == ssm_pkg::ST_IGN)
    else $error("byte mode accepted a second byte");
  write_seen_c: cover property (we ##[1:400] we);
  read_seen_c: cover property (st_q == ssm_pkg::ST_RD && |O_LANE_OE);
  pause_seen_c: cover property ($rose(paused_q) ##[1:400] $fell(paused_q));
  quad_seen_c: cover property (quad && we);
endmodule
`default_nettype wire

// ### logic/ssm_pkg.sv
// constants and types shared by the serial sram port
`default_nettype none
package ssm_pkg;
  localparam int ADDR_W = 18;
  localparam int PAGE_W = 5;
  // link field lengths in bits
  localparam logic [4:0] INSTR_BITS = 5'h08;
  localparam logic [4:0] ADDR_BITS  = 5'h18;
  localparam logic [4:0] DUMMY_BITS = 5'h08;
  localparam logic [4:0] DATA_BITS  = 5'h08;
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  // instruction codes
  localparam logic [7:0] CMD_READ  = 8'h03;
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] CMD_ENTER_DUAL = 8'h3b;
  localparam logic [7:0] CMD_ENTER_QUAD = 8'h38;
  localparam logic [7:0] CMD_EXIT_MULTI = 8'hff;
  localparam logic [7:0] CMD_READ_MODE  = 8'h05;
  localparam logic [7:0] CMD_WRITE_MODE = 8'h01;
  // mode register access field, bits 7:6
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam logic [1:0] MODE_BYTE  = 2'h0;
  localparam logic [1:0] MODE_PAGE  = 2'h2;
  localparam logic [1:0] MODE_SEQ   = 2'h1;
  localparam logic [1:0] MODE_RSVD  = 2'h3;
  localparam logic [1:0] MODE_RESET = MODE_SEQ;
  // synchroniser reset: {lane3..0, sck, cs_n}, cs_n and pause high
  localparam logic [5:0] SYNC_RESET = 6'h21;
  // lane enables per width
  localparam logic [3:0] OE_SINGLE = 4'h2;
  localparam logic [3:0] OE_DUAL   = 4'h3;
  localparam logic [3:0] OE_QUAD   = 4'hf;

  typedef enum logic [1:0] {
    LANE_SINGLE = 2'b00,
    LANE_DUAL   = 2'b01,
    LANE_QUAD   = 2'b10
  } ssm_lane_t;

  typedef enum logic [2:0] {
    ST_CMD   = 3'b000,
    ST_ADDR  = 3'b001,
    ST_DUMMY = 3'b010,
    ST_WR    = 3'b011,
    ST_MWR   = 3'b100,
    ST_RD    = 3'b101,
    ST_IGN   = 3'b110
  } ssm_state_t;
endpackage
`default_nettype wire

// ### sim/ssm_master_model.sv
// bus master model driving the serial sram port link
`default_nettype none
module ssm_master_model (
  input  wire logic       i_clk,
  input  wire logic [3:0] i_dut_lane,
  input  wire logic [3:0] i_dut_oe,
  output var  logic       o_cs_n,
  output var  logic       o_sck,
  output var  logic [3:0] o_lane
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] m_out;
  logic [3:0] m_oe;
  logic [3:0] rx_oe;
  logic       junk;
  int         width;
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    m_out = 4'h8; // pause pin held high while unused
    m_oe = 4'h8;
    junk = 1'b0;
    width = 1;
  end
  // released lanes toggle so a stale level never passes for data
  always @(posedge i_clk) junk <= #1 ~junk;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      o_lane[i] = i_dut_oe[i] ? i_dut_lane[i] : m_oe[i] ? m_out[i] : junk;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic frame_start();
    m_oe = (width == 4) ? 4'h0 : 4'h8;
    o_sck = 1'b0;
    o_cs_n = 1'b0;
    tick(4);
  endtask
  task automatic frame_end();
    o_sck = 1'b0;
    tick(4);
    o_cs_n = 1'b1;
    tick(8);
  endtask
  task automatic bit_cyc(input logic [3:0] nib, output logic [3:0] got);
    o_sck = 1'b0;
    m_out = (width == 4) ? nib : {m_out[3], nib[2:0]};
    tick(4);
    got = o_lane;
    rx_oe = i_dut_oe;
    o_sck = 1'b1; // data set up before the rise
    tick(4);
  endtask
  task automatic send(input logic [7:0] b); // msb first
    logic [3:0] g;
    m_oe = (width == 4) ? 4'hf : (width == 2) ? 4'hb : 4'h9;
    for (int i = 0; i < 8 / width; i++) begin
      bit_cyc(b[7:4] >> (4 - width), g);
      b = b << width;
    end
  endtask
  task automatic recv(output logic [7:0] b);
    logic [3:0] g;
    m_oe = (width == 4) ? 4'h0 : 4'h8;
    b = 8'h00;
    for (int i = 0; i < 8 / width; i++) begin
      bit_cyc(4'h0, g);
      b = (width == 1) ? {b[6:0], g[1]} :
          (width == 2) ? {b[5:0], g[1:0]} : {b[3:0], g};
    end
  endtask
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// self-checking bench for the serial sram port
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic       mclk;
  logic       rst;
  logic       cs_n;
  logic       sck;
  logic [3:0] lane;
  logic [3:0] o_lane;
  logic [3:0] o_oe;
  int         n_fail;
  int         checks;
  ssm_sram_port u_dut (.I_MCLK(mclk), .I_RESET(rst), .I_CS_N(cs_n),
    .I_SCK(sck), .I_LANE(lane), .O_LANE(o_lane), .O_LANE_OE(o_oe));
  ssm_master_model u_mst (.i_clk(mclk), .i_dut_lane(o_lane),
    .i_dut_oe(o_oe), .o_cs_n(cs_n), .o_sck(sck), .o_lane(lane));
  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;
  task automatic tally_and_finish();
    if (n_fail == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cmd_addr(input logic [7:0] c, input logic [23:0] a);
    u_mst.frame_start();
    u_mst.send(c);
    u_mst.send(a[23:16]);
    u_mst.send(a[15:8]);
    u_mst.send(a[7:0]);
  endtask
  task automatic wr_mode(input logic [7:0] v); // low bits zero
    u_mst.frame_start();
    u_mst.send(ssm_pkg::CMD_WRITE_MODE);
    u_mst.send(v);
    u_mst.frame_end();
  endtask
  task automatic rd_mode(input logic [7:0] exp);
    logic [7:0] r;
    u_mst.frame_start();
    u_mst.send(ssm_pkg::CMD_READ_MODE);
    repeat (2) begin
      u_mst.recv(r);
      check(r, exp);
    end
    u_mst.frame_end();
  endtask
  task automatic mem_wr(input logic [23:0] a, input int n,
                        input logic [7:0] b0, b1, b2);
    logic [7:0] d [0:2];
    d = '{b0, b1, b2};
    cmd_addr(ssm_pkg::CMD_WRITE, a);
    for (int i = 0; i < n; i++) begin
      u_mst.send(d[i]);
    end
    u_mst.frame_end();
  endtask
  task automatic mem_rd(input logic [23:0] a, input int n,
                        input logic [7:0] b0, b1, b2);
    logic [7:0] d [0:2];
    logic [7:0] r;
    logic [3:0] oe;
    d = '{b0, b1, b2};
    oe = (u_mst.width == 4) ? ssm_pkg::OE_QUAD :
         (u_mst.width == 2) ? ssm_pkg::OE_DUAL : ssm_pkg::OE_SINGLE;
    cmd_addr(ssm_pkg::CMD_READ, a);
    if (u_mst.width > 1)
      u_mst.recv(r);
    for (int i = 0; i < n; i++) begin
      u_mst.recv(r);
      check(r, d[i]);
      check({4'h0, u_mst.rx_oe}, {4'h0, oe});
    end
    u_mst.frame_end();
    check({4'h0, o_oe}, 8'h00);
  endtask
  task automatic sc_seq();
    mem_wr(24'hfffffe, 3, 8'h11, 8'ha5, 8'h3c);
    mem_rd(24'h03fffe, 3, 8'h11, 8'ha5, 8'h3c);
    mem_rd(24'h000000, 1, 8'h3c, 8'h00, 8'h00);
  endtask
  task automatic sc_page();
    mem_wr(24'h000120, 1, 8'h00, 8'h00, 8'h00);
    wr_mode(8'h80);
    mem_wr(24'h00011f, 2, 8'h5a, 8'hc3, 8'h00);
    mem_rd(24'h00011f, 2, 8'h5a, 8'hc3, 8'h00);
    mem_rd(24'h000120, 1, 8'h00, 8'h00, 8'h00);
  endtask
  task automatic sc_byte();
    logic [7:0] r;
    wr_mode(8'h00);
    wr_mode(8'hc0);
    rd_mode(8'h00);
    mem_wr(24'h000201, 1, 8'h5a, 8'h00, 8'h00);
    mem_wr(24'h000200, 2, 8'h77, 8'h88, 8'h00);
    mem_rd(24'h000201, 1, 8'h5a, 8'h00, 8'h00);
    cmd_addr(ssm_pkg::CMD_READ, 24'h000200);
    u_mst.recv(r);
    check(r, 8'h77);
    u_mst.recv(r);
    check({4'h0, u_mst.rx_oe}, 8'h00);
    u_mst.frame_end();
    wr_mode(8'h40);
  endtask
  task automatic sc_pause();
    logic [7:0] r;
    cmd_addr(ssm_pkg::CMD_READ, 24'h03fffe);
    u_mst.recv(r);
    check(r, 8'h11);
    u_mst.o_sck = 1'b0;
    u_mst.tick(4);
    u_mst.m_out[3] = 1'b0; // asserted with clock low
    u_mst.tick(5);
    check({4'h0, o_oe}, 8'h00);
    repeat (3) begin
      u_mst.o_sck = 1'b1;
      u_mst.tick(4);
      u_mst.o_sck = 1'b0;
      u_mst.tick(4);
    end
    u_mst.m_out[3] = 1'b1; // released with clock low
    u_mst.tick(5);
    check({4'h0, o_oe}, 8'h02);
    u_mst.recv(r);
    check(r, 8'ha5); // clock edges in the pause ignored
    u_mst.frame_end();
  endtask
  task automatic sc_unknown();
    logic [7:0] r;
    cmd_addr(8'h9a, 24'h03fffe);
    u_mst.recv(r);
    check({4'h0, u_mst.rx_oe}, 8'h00);
    u_mst.frame_end();
  endtask
  task automatic sc_lanes(input logic [7:0] enter, input int w);
    u_mst.frame_start();
    u_mst.send(enter);
    u_mst.frame_end();
    u_mst.width = w;
    mem_wr(24'h000040, 2, 8'h96, 8'h4b, 8'h00);
    mem_rd(24'h000040, 2, 8'h96, 8'h4b, 8'h00);
    u_mst.frame_start();
    u_mst.send(ssm_pkg::CMD_EXIT_MULTI);
    u_mst.frame_end();
    u_mst.width = 1;
    rd_mode(8'h40);
  endtask
  task automatic sc_reset(); // mid-run reset: single lane, sequential mode
    wr_mode(8'h80);
    u_mst.frame_start();
    u_mst.send(ssm_pkg::CMD_ENTER_DUAL);
    u_mst.frame_end();
    rst = 1'b1;
    u_mst.tick(3);
    rst = 1'b0;
    u_mst.tick(3);
    rd_mode(8'h40);
  endtask
  initial begin
    n_fail = 0;
    checks = 0;
    rst = 1'b1;
    repeat (20) @(posedge mclk);
    #1 rst = 1'b0;
    u_mst.tick(3);
    rd_mode(8'h40);
    sc_seq();
    sc_page();
    sc_byte();
    sc_pause();
    sc_unknown();
    sc_lanes(ssm_pkg::CMD_ENTER_DUAL, 2);
    sc_lanes(ssm_pkg::CMD_ENTER_QUAD, 4);
    sc_reset();
    tally_and_finish();
  end
  // a hang is cut short and counted as a mismatch
  initial begin
    repeat (100000) @(posedge mclk);
    n_fail++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
